// [hw/umsp_pkg.sv]
// Constants for the modem and serial pin block
// Behaviour
// [R1] Normal mode: transmit line high when idle
// [R2] Infrared mode: transmit line idles low
// [R3] Reset always selects normal serial mode
// [R4] Partner idles receive line per mode
// [R5] Request-to-send low while its control bit set
// [R6] Optional automatic request-to-send from receive level
// [R7] Request-to-send high after reset and idle
// [R8] Loopback forces request-to-send high
// [R9] Terminal-ready low while its control bit set
// [R10] Terminal-ready high after reset and idle
// [R11] Loopback forces terminal-ready high
// [R12] Status bit 4 is inverted clear-to-send
// [R13] Status bit 0 flags clear-to-send change
// [R14] Clear-to-send can gate the transmitter
// [R15] Clear-to-send change raises enabled interrupt
// [R16] Status bit 5 is inverted set-ready
// [R17] Status bit 1 flags set-ready change
// [R18] Set-ready change raises enabled interrupt
// [R19] Interrupt high while enabled condition pending
// [R20] Status read clears flags; inputs synchronised
package umsp_pkg;
    localparam logic [7:0] ADDR_TX = 8'h00;
    localparam logic [7:0] ADDR_IER = 8'h04;
    localparam logic [7:0] ADDR_TRIG = 8'h08;
    localparam logic [7:0] ADDR_DIV = 8'h0C;
    localparam logic [7:0] ADDR_MCR = 8'h10;
    localparam logic [7:0] ADDR_MSR = 8'h18;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_LOOP = 4;
    localparam int MCR_AUTO = 5;
    localparam int MCR_IR = 6;
    localparam int IER_MODEM = 3;
    localparam int MSR_DCTS = 0;
    localparam int MSR_DDSR = 1;
    localparam int MSR_CTS = 4;
    localparam int MSR_DSR = 5;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [6:0] TRIG_RST = 7'h08;
    localparam logic [15:0] DIV_RST = 16'h000D;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] FRAME_BITS = 4'hA;
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] IR_TICKS = 4'h3;
endpackage : umsp_pkg

// [hw/umsp_top.sv]
// Serial and modem pin logic of one channel behind an AXI4-Lite slave
`timescale 1ns/1ps
module umsp_top
    import umsp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic serial_tx_out,
    output logic rts_n_out,
    output logic dtr_n_out,
    input wire logic cts_n_in,
    input wire logic dsr_n_in,
    input wire logic [6:0] rx_fifo_level,
    output logic channel_irq_out
);
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        return (a == ADDR_TX) || (a == ADDR_IER) || (a == ADDR_TRIG) ||
               (a == ADDR_DIV) || (a == ADDR_MCR) || (a == ADDR_MSR);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////
    // Write channel
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_d, awready_d, wready_d, do_wr;
    logic [1:0] bresp_d;

    always_comb begin
        aw_got_d = aw_got_q | (s_axi_awvalid & s_axi_awready);
        w_got_d = w_got_q | (s_axi_wvalid & s_axi_wready);
        awaddr_d = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_q;
        wdata_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_q;
        wstrb_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_q;
        do_wr = aw_got_d & w_got_d & ~s_axi_bvalid;
        bresp_d = s_axi_bresp;
        if (do_wr) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bresp_d = mapped(awaddr_d) ? RESP_OKAY : RESP_SLVERR;
        end
        bvalid_d = do_wr | (s_axi_bvalid & ~s_axi_bready);
        awready_d = ~aw_got_d & ~bvalid_d;
        wready_d = ~w_got_d & ~bvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            s_axi_awready <= awready_d;
            s_axi_wready <= wready_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control registers, baud divider, modem status
    logic [7:0] mcr_q, mcr_d, ier_q, ier_d, msr_q, msr_d, txd_q, txd_d;
    logic [6:0] trig_q, trig_d;
    logic [15:0] div_q, div_d, cnt_q, cnt_d;
    logic tick_q, tick_d, pend_q, pend_d, tx_busy, tx_start, cts_ok, msr_read;
    logic cts_s1_q, cts_s2_q, cts_p_q, dsr_s1_q, dsr_s2_q, dsr_p_q;
    logic [31:0] m;

    always_comb begin
        mcr_d = mcr_q;
        ier_d = ier_q;
        trig_d = trig_q;
        div_d = div_q;
        txd_d = txd_q;
        pend_d = pend_q;
        m = 32'h0000_0000;
        if (do_wr) begin
            m = merge(32'h0000_0000, wdata_d, wstrb_d);
            unique case (awaddr_d)
                ADDR_TX: begin
                    if (wstrb_d[0] && !pend_q) begin
                        txd_d = m[7:0];
                        pend_d = 1'b1;
                    end
                end
                ADDR_IER: begin
                    m = merge({24'h00_0000, ier_q}, wdata_d, wstrb_d);
                    ier_d = m[7:0];
                end
                ADDR_TRIG: begin
                    m = merge({25'h000_0000, trig_q}, wdata_d, wstrb_d);
                    trig_d = m[6:0];
                end
                ADDR_DIV: begin
                    m = merge({16'h0000, div_q}, wdata_d, wstrb_d);
                    div_d = m[15:0];
                end
                ADDR_MCR: begin
                    m = merge({24'h00_0000, mcr_q}, wdata_d, wstrb_d);
                    mcr_d = m[7:0];
                end
                default: ;
            endcase
        end
        // Auto clear-to-send: send only while partner is ready
        cts_ok = ~mcr_q[MCR_AUTO] | msr_q[MSR_CTS]; // [R14]
        tx_start = pend_q & ~tx_busy & cts_ok;
        if (tx_start) begin
            pend_d = 1'b0;
        end
        tick_d = 1'b0;
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q >= div_q - 16'h0001) begin
            cnt_d = 16'h0000;
            tick_d = 1'b1;
        end
        msr_d = msr_q;
        msr_d[MSR_CTS] = ~cts_s2_q; // [R12]
        msr_d[MSR_DSR] = ~dsr_s2_q; // [R16]
        // A change in the read cycle survives the clear
        msr_d[MSR_DCTS] = (cts_s2_q ^ cts_p_q) | (msr_q[MSR_DCTS] & ~msr_read); // [R13] [R20]
        msr_d[MSR_DDSR] = (dsr_s2_q ^ dsr_p_q) | (msr_q[MSR_DDSR] & ~msr_read); // [R17] [R20]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mcr_q <= MCR_RST; // [R3]
            ier_q <= IER_RST;
            trig_q <= TRIG_RST;
            div_q <= DIV_RST;
            txd_q <= 8'h00;
            pend_q <= 1'b0;
            cnt_q <= 16'h0000;
            tick_q <= 1'b0;
            msr_q <= 8'h00;
            cts_s1_q <= 1'b1;
            cts_s2_q <= 1'b1;
            cts_p_q <= 1'b1;
            dsr_s1_q <= 1'b1;
            dsr_s2_q <= 1'b1;
            dsr_p_q <= 1'b1;
        end else begin
            mcr_q <= mcr_d;
            ier_q <= ier_d;
            trig_q <= trig_d;
            div_q <= div_d;
            txd_q <= txd_d;
            pend_q <= pend_d;
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            msr_q <= msr_d;
            cts_s1_q <= cts_n_in; // [R20]
            cts_s2_q <= cts_s1_q;
            cts_p_q <= cts_s2_q;
            dsr_s1_q <= dsr_n_in;
            dsr_s2_q <= dsr_s1_q;
            dsr_p_q <= dsr_s2_q;
        end
    end

    umsp_tx u_tx (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick16(tick_q),
        .start(tx_start),
        .data(txd_q),
        .ir_mode(mcr_q[MCR_IR]), // [R2]
        .busy(tx_busy),
        .line(serial_tx_out) // [R1]
    );

    ////////////////////////////////////////////////////////////////
    // Read channel
    logic rd, rvalid_d, arready_d;
    logic [31:0] rdata_d;
    logic [1:0] rresp_d;

    always_comb begin
        rd = s_axi_arvalid & s_axi_arready;
        msr_read = rd && (s_axi_araddr == ADDR_MSR); // [R20]
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        if (rd) begin
            rresp_d = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                ADDR_TX: rdata_d = {30'h0000_0000, pend_q, tx_busy};
                ADDR_IER: rdata_d = {24'h00_0000, ier_q};
                ADDR_TRIG: rdata_d = {25'h000_0000, trig_q};
                ADDR_DIV: rdata_d = {16'h0000, div_q};
                ADDR_MCR: rdata_d = {24'h00_0000, mcr_q};
                ADDR_MSR: rdata_d = {24'h00_0000, msr_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        rvalid_d = rd | (s_axi_rvalid & ~s_axi_rready);
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
            s_axi_arready <= arready_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Handshake pins and interrupt
    logic rts_n_d, dtr_n_d, irq_d, rx_full;

    always_comb begin
        rx_full = mcr_d[MCR_AUTO] & (rx_fifo_level >= trig_d); // [R6]
        rts_n_d = mcr_d[MCR_LOOP] | ~(mcr_d[MCR_RTS] & ~rx_full); // [R5] [R7] [R8]
        dtr_n_d = mcr_d[MCR_LOOP] | ~mcr_d[MCR_DTR]; // [R9] [R10] [R11]
        irq_d = ier_d[IER_MODEM] & (msr_d[MSR_DCTS] | msr_d[MSR_DDSR]); // [R15] [R18] [R19]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rts_n_out <= 1'b1; // [R7]
            dtr_n_out <= 1'b1; // [R10]
            channel_irq_out <= 1'b0;
        end else begin
            rts_n_out <= rts_n_d;
            dtr_n_out <= dtr_n_d;
            channel_irq_out <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence cts_low_s;
        (cts_n_in == 1'b0) [*4];
    endsequence
    sequence dsr_high_s;
        (dsr_n_in == 1'b1) [*4];
    endsequence

    reset_pins_a: assert property ($past(!aresetn) |-> rts_n_out && dtr_n_out // [R3]
        && !mcr_q[MCR_IR]) else $error("pins not inactive after reset");
    tx_norm_a: assert property ((!tx_busy && !mcr_q[MCR_IR]) [*2] |-> serial_tx_out) // [R1]
        else $error("normal idle line not high");
    tx_ir_a: assert property ((!tx_busy && mcr_q[MCR_IR]) [*2] |-> !serial_tx_out) // [R2]
        else $error("infrared idle line not low");
    rts_ctl_a: assert property (!mcr_q[MCR_LOOP] && !mcr_q[MCR_AUTO] |-> // [R5]
        (rts_n_out == !mcr_q[MCR_RTS])) else $error("rts does not follow control bit");
    rts_auto_a: assert property (mcr_q[MCR_AUTO] && (rx_fifo_level >= trig_q) // [R6]
        |=> rts_n_out) else $error("auto rts not released");
    loop_pins_a: assert property (mcr_q[MCR_LOOP] |-> rts_n_out && dtr_n_out) // [R8]
        else $error("loopback did not park pins");
    dtr_ctl_a: assert property (!mcr_q[MCR_LOOP] |-> (dtr_n_out == !mcr_q[MCR_DTR])) // [R9]
        else $error("dtr does not follow control bit");
    cts_stat_a: assert property (cts_low_s |-> msr_q[MSR_CTS]) // [R12]
        else $error("cts status not inverted");
    dsr_stat_a: assert property (dsr_high_s |-> !msr_q[MSR_DSR]) // [R16]
        else $error("dsr status not inverted");
    cts_delta_a: assert property ($changed(cts_s2_q) |-> ##1 msr_q[MSR_DCTS]) // [R13]
        else $error("cts change not flagged");
    dsr_delta_a: assert property ($changed(dsr_s2_q) |-> ##1 msr_q[MSR_DDSR]) // [R17]
        else $error("dsr change not flagged");
    msr_clear_a: assert property (msr_read && !$changed(cts_s2_q) && !$changed(dsr_s2_q) // [R20]
        |=> !msr_q[MSR_DCTS] && !msr_q[MSR_DDSR]) else $error("status read did not clear");
    irq_modem_a: assert property (ier_q[IER_MODEM] && (msr_q[MSR_DCTS] || msr_q[MSR_DDSR]) // [R19]
        |-> channel_irq_out) else $error("modem interrupt missing");
    irq_quiet_a: assert property (!msr_q[MSR_DCTS] && !msr_q[MSR_DDSR] // [R15] [R18]
        |-> !channel_irq_out) else $error("interrupt without cause");
    cts_hold_a: assert property (!tx_busy && mcr_q[MCR_AUTO] && !msr_q[MSR_CTS] // [R14]
        |=> !tx_busy) else $error("sent while partner not ready");
endmodule : umsp_top

// [hw/umsp_tx.sv]
// Character shifter for the transmit line, normal or infrared
`timescale 1ns/1ps
module umsp_tx
    import umsp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick16,
    input wire logic start,
    input wire logic [7:0] data,
    input wire logic ir_mode,
    output logic busy,
    output logic line
);
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } umsp_tx_state_type;

    umsp_tx_state_type state_q, state_d;
    logic [9:0] shreg_q, shreg_d;
    logic [3:0] bit_q, bit_d;
    logic [3:0] sub_q, sub_d;
    logic line_d, busy_d, cur;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        shreg_d = shreg_q;
        bit_d = bit_q;
        sub_d = sub_q;
        unique case (state_q)
            TX_IDLE: begin
                if (start) begin
                    state_d = TX_SHIFT;
                    shreg_d = {1'b1, data, 1'b0};
                    bit_d = 4'h0;
                    sub_d = 4'h0;
                end
            end
            TX_SHIFT: begin
                if (tick16) begin
                    if (sub_q == SUB_LAST) begin
                        sub_d = 4'h0;
                        shreg_d = {1'b1, shreg_q[9:1]};
                        if (bit_q == FRAME_BITS - 4'h1) begin
                            state_d = TX_IDLE;
                        end else begin
                            bit_d = bit_q + 4'h1;
                        end
                    end else begin
                        sub_d = sub_q + 4'h1;
                    end
                end
            end
        endcase
        cur = (state_d == TX_SHIFT) ? shreg_d[0] : 1'b1;
        // Infrared: short high pulse for each zero, low otherwise
        line_d = ir_mode ? (~cur & (sub_d < IR_TICKS)) : cur; // [R1] [R2]
        busy_d = (state_d == TX_SHIFT);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= TX_IDLE;
            shreg_q <= 10'h3FF;
            bit_q <= 4'h0;
            sub_q <= 4'h0;
            line <= 1'b1; // [R1] [R3]
            busy <= 1'b0;
        end else begin
            state_q <= state_d;
            shreg_q <= shreg_d;
            bit_q <= bit_d;
            sub_q <= sub_d;
            line <= line_d;
            busy <= busy_d;
        end
    end
endmodule : umsp_tx

// [test/umsp_partner.sv]
// Modem and line partner facing the serial pins
`timescale 1ns/1ps
module umsp_partner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cts_cmd,
    input wire logic dsr_cmd,
    input wire logic [6:0] level_cmd,
    input wire logic ir_mode,
    output logic cts_n_in,
    output logic dsr_n_in,
    output logic [6:0] rx_fifo_level,
    output logic serial_rx_in
);
    // Handshake lines inactive while in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cts_n_in <= 1'b1;
            dsr_n_in <= 1'b1;
            rx_fifo_level <= 7'h00;
        end else begin
            cts_n_in <= cts_cmd;
            dsr_n_in <= dsr_cmd;
            rx_fifo_level <= level_cmd;
        end
    end
    // Receive line idles at the level of the mode
    assign serial_rx_in = ir_mode ? 1'b0 : 1'b1;
endmodule : umsp_partner

// [test/umsp_top_tb_top.sv]
// Self-checking bench for the serial and modem pin block
`timescale 1ns/1ps
module umsp_top_tb_top
    import umsp_pkg::*;
;
    logic aclk = 0, aresetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid, tx, rts_n, dtr_n, irq, cts_n, dsr_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, seed = 32'h0000_6214;
    logic cts_cmd = 1, dsr_cmd = 1, ir = 0;
    logic [6:0] level_cmd = 0, lvl;
    logic [6:0] fifo_lvl;
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] m;
    int miscompares = 0, check_count = 0;

    always #25 aclk = ~aclk;

    umsp_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_tx_out(tx), .rts_n_out(rts_n), .dtr_n_out(dtr_n),
        .cts_n_in(cts_n), .dsr_n_in(dsr_n), .rx_fifo_level(fifo_lvl),
        .channel_irq_out(irq));

    umsp_partner u_partner (.aclk(aclk), .aresetn(aresetn), .cts_cmd(cts_cmd),
        .dsr_cmd(dsr_cmd), .level_cmd(level_cmd), .ir_mode(ir), .cts_n_in(cts_n),
        .dsr_n_in(dsr_n), .rx_fifo_level(fifo_lvl), .serial_rx_in());

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Pin levels {tx idle, rts_n, dtr_n} expected from a control value
    function automatic logic [2:0] pins(input logic [7:0] c);
        return {~c[MCR_IR], ~(c[MCR_RTS] & ~c[MCR_LOOP]), ~(c[MCR_DTR] & ~c[MCR_LOOP])};
    endfunction : pins

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic stop_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        awaddr <= a;
        awvalid <= 1;
        wdata <= v;
        wstrb <= 4'hF;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 0;
    endtask : rd

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
        wr(a, v, r);
        chk("bresp", RESP_OKAY, r);
        repeat (2) @(posedge aclk);
    endtask : wr_ok

    task automatic pin_chk(input logic [7:0] c);
        #1;
        chk("pins", pins(c), {tx, rts_n, dtr_n});
    endtask : pin_chk

    task automatic msr_chk(input logic [7:0] e, input logic ei);
        #1;
        chk("irq", ei, irq);
        rd(ADDR_MSR, d, r);
        chk("msr", e, d[7:0]);
        repeat (2) @(posedge aclk);
    endtask : msr_chk

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        #1;
        chk("reset pins", 4'b1110, {tx, rts_n, dtr_n, irq});
        rd(ADDR_MSR, d, r);
        chk("msr reset", 32'h0000_0000, d);
        // Random control values over the pin bits
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            m = seed[7:0] & 8'h53;
            ir <= m[MCR_IR];
            wr_ok(ADDR_MCR, {24'h00_0000, m});
            pin_chk(m);
        end
        // Infrared then reset in mid-run
        wr_ok(ADDR_MCR, 32'h0000_0043);
        pin_chk(8'h43);
        aresetn <= 0;
        ir <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        #1;
        chk("rereset pins", 3'b111, {tx, rts_n, dtr_n});
        // Automatic request-to-send against trigger level
        wr_ok(ADDR_TRIG, 32'h0000_0010);
        wr_ok(ADDR_MCR, 32'h0000_0022);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            lvl = (i < 2) ? 7'h0F + 7'(i) : seed[6:0] & 7'h1F;
            level_cmd <= lvl;
            repeat (4) @(posedge aclk);
            #1;
            chk("auto rts", lvl >= 7'h10, rts_n);
        end
        // Modem input changes, flags, interrupt and clear on read
        wr_ok(ADDR_MCR, 32'h0000_0000);
        wr_ok(ADDR_IER, 32'h0000_0008);
        cts_cmd <= 0;
        repeat (6) @(posedge aclk);
        msr_chk(8'h11, 1'b1);
        msr_chk(8'h10, 1'b0);
        dsr_cmd <= 0;
        repeat (6) @(posedge aclk);
        msr_chk(8'h32, 1'b1);
        cts_cmd <= 1;
        repeat (6) @(posedge aclk);
        msr_chk(8'h21, 1'b1);
        msr_chk(8'h20, 1'b0);
        // Interrupt masked while enable bit clear
        wr_ok(ADDR_IER, 32'h0000_0000);
        dsr_cmd <= 1;
        repeat (6) @(posedge aclk);
        #1;
        chk("irq masked", 1'b0, irq);
        msr_chk(8'h02, 1'b0);
        // Unmapped place refused
        wr(8'h1C, 32'h0000_0001, r);
        chk("bresp unmapped", RESP_SLVERR, r);
        rd(8'h1C, d, r);
        chk("rresp unmapped", {30'h0, RESP_SLVERR}, {d[29:0], r});
        // Transmit held by clear-to-send, then one frame
        wr_ok(ADDR_DIV, 32'h0000_0001);
        wr_ok(ADDR_MCR, 32'h0000_0020);
        seed = lfsr(seed);
        m = seed[7:0];
        wr_ok(ADDR_TX, {24'h00_0000, m});
        repeat (40) @(posedge aclk);
        #1;
        chk("tx held", 1'b1, tx);
        cts_cmd <= 0;
        for (int i = 0; i < 100 && tx !== 1'b0; i++) @(posedge aclk);
        repeat (8) @(posedge aclk);
        #1;
        chk("start bit", 1'b0, tx);
        for (int b = 0; b < 9; b++) begin
            repeat (16) @(posedge aclk);
            #1;
            chk("frame bit", (b < 8) ? m[b] : 1'b1, tx);
        end
        repeat (200) @(posedge aclk);
        #1;
        chk("tx idle", 1'b1, tx);
        stop_test();
    end
endmodule : umsp_top_tb_top
